/* File: verilog/mbd_core.v */
`include "mbd_consts.vh"

// Contract
// RULE_01: E8-EF copy register to A, 1 cycle
// RULE_02: E5 load A from direct, 2B 2cyc
// RULE_03: E6-E7 load A indirect, 1B 2cyc
// RULE_04: 74 load A immediate, 2B 2cyc
// RULE_05: F8-FF copy A to register, 1cyc
// RULE_06: A8-AF register from direct, 2B 3cyc
// RULE_07: 85 direct to direct, 3B 3cyc
// RULE_08: 90 load data pointer, 3B 3cyc
// RULE_09: 93 code byte at A+DPTR, 5cyc
// RULE_10: 83 code byte at A+PC, 4cyc
// RULE_11: E2-E3 external 8-bit read, 3cyc
// RULE_12: F2-F3 external write 4/5, small 3
// RULE_13: F0 external write 3/4, small 2
// RULE_14: push 3cyc, pop 2cyc, both 2B
// RULE_15: C5 swap A with direct, 2B 3cyc
// RULE_16: D6-D7 swap low nibble, 1B 3cyc
// RULE_17: 73 jump to A+DPTR, 5cyc
// RULE_18: 60 branch if A zero, 4cyc
// RULE_19: 40 branch if carry, 2B 3cyc
// RULE_20: 10 branch on bit and clear, 5cyc
// RULE_21: B5 compare direct, branch unequal, 5cyc
// RULE_22: D8-DF decrement register, branch nonzero, 4cyc
// RULE_23: external timing stretches, counts are minimum
// RULE_24: absolute forms take target bits 10:8
module mbd_core
(
  input  wire        clk_in,
  input  wire        reset_in,
  input  wire        issue_in,
  input  wire [7:0]  opcode_in,
  input  wire [7:0]  operand1_in,
  input  wire [7:0]  operand2_in,
  input  wire [15:0] pc_in,
  input  wire [7:0]  acc_in,
  input  wire [15:0] dptr_in,
  input  wire        carry_in,
  input  wire        bit_in,
  input  wire [7:0]  direct_data_in,
  input  wire [7:0]  reg_data_in,
  input  wire        small_external_data_memory_in,
  input  wire        code_int_in,
  input  wire        ext_wait_in,
  output reg         ready_out,
  output reg  [4:0]  class_out,
  output reg  [1:0]  bytes_out,
  output reg  [2:0]  cycles_out,
  output reg         done_out,
  output reg         branch_out,
  output reg  [15:0] target_out,
  output reg         bit_clear_out,
  output reg  [7:0]  reg_result_out,
  output reg  [15:0] code_addr_out
);

  wire [4:0]  dec_class;
  wire [1:0]  dec_bytes;
  wire [2:0]  dec_cycles;
  wire        busy;
  wire        last;
  wire        start;
  wire        stretchable;
  wire [15:0] next_pc;
  wire [15:0] rel_target;
  wire [7:0]  reg_dec;

  reg         branch_d;
  reg  [15:0] target_d;
  reg  [15:0] code_addr_d;
  reg  [7:0]  acc_q;
  reg  [7:0]  reg_q;
  reg  [7:0]  direct_q;
  reg         carry_q;
  reg         bit_q;
  reg  [7:0]  op1_q;
  reg  [7:0]  op2_q;
  reg  [15:0] dptr_q;
  reg  [15:0] pc_q;
  reg  [4:0]  class_q;
  reg  [1:0]  bytes_q;
  reg  [2:0]  opc_hi_q;

  // sign-extend a relative displacement
  function [15:0] sext;
    input [7:0] rel;
    begin
      sext = {{8{rel[7]}}, rel};
    end
  endfunction

  mbd_decode u_decode
  (
    .opcode_in   (opcode_in),
    .small_external_data_memory_in     (small_external_data_memory_in),
    .code_int_in (code_int_in),
    .class_out   (dec_class),
    .bytes_out   (dec_bytes),
    .cycles_out  (dec_cycles)
  );

  // only the external-memory transfers may be stretched by waits
  assign stretchable = (dec_class == `MBD_CLS_MOVX_RD8) || (dec_class == `MBD_CLS_MOVX_WR8) ||
                       (dec_class == `MBD_CLS_MOVX_WR16);  // RULE_23
  assign start = issue_in && !busy;

  mbd_cycle_timer u_timer
  (
    .clk_in         (clk_in),
    .reset_in       (reset_in),
    .start_in       (start),
    .cycles_in      (dec_cycles),
    .stretchable_in (stretchable),
    .ext_wait_in    (ext_wait_in),
    .busy_out       (busy),
    .last_out       (last)
  );

  assign next_pc    = pc_q + {14'h0000, bytes_q};
  assign rel_target = next_pc + sext(class_q == `MBD_CLS_JBC || class_q == `MBD_CLS_CJNE_DIR ? op2_q : op1_q);
  assign reg_dec    = reg_q - 8'h01;

  // capture operands at issue so the outcome is stable through execution
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      acc_q    <= 8'h00;
      reg_q    <= 8'h00;
      direct_q <= 8'h00;
      carry_q  <= 1'b0;
      bit_q    <= 1'b0;
      op1_q    <= 8'h00;
      op2_q    <= 8'h00;
      dptr_q   <= 16'h0000;
      pc_q     <= 16'h0000;
      class_q  <= `MBD_CLS_OTHER;
      bytes_q  <= 2'h1;
      opc_hi_q <= 3'h0;
    end
    else if (start)
    begin
      acc_q    <= acc_in;
      reg_q    <= reg_data_in;
      direct_q <= direct_data_in;
      carry_q  <= carry_in;
      bit_q    <= bit_in;
      op1_q    <= operand1_in;
      op2_q    <= operand2_in;
      dptr_q   <= dptr_in;
      pc_q     <= pc_in;
      class_q  <= dec_class;
      bytes_q  <= dec_bytes;
      opc_hi_q <= opcode_in[7:5];
    end
  end

  always @*
  begin
    branch_d    = 1'b0;
    target_d    = next_pc;
    code_addr_d = 16'h0000;
    case (class_q)
      `MBD_CLS_MOVC_DPTR:
      begin
        code_addr_d = dptr_q + {8'h00, acc_q};  // RULE_09
      end
      `MBD_CLS_MOVC_PC:
      begin
        code_addr_d = next_pc + {8'h00, acc_q};  // RULE_10
      end
      `MBD_CLS_JMP_IND:
      begin
        branch_d = 1'b1;
        target_d = dptr_q + {8'h00, acc_q};  // RULE_17
      end
      `MBD_CLS_JZ:
      begin
        branch_d = (acc_q == 8'h00);  // RULE_18
        target_d = branch_d ? rel_target : next_pc;
      end
      `MBD_CLS_JC:
      begin
        branch_d = carry_q;  // RULE_19
        target_d = branch_d ? rel_target : next_pc;
      end
      `MBD_CLS_JBC:
      begin
        branch_d = bit_q;  // RULE_20
        target_d = branch_d ? rel_target : next_pc;
      end
      `MBD_CLS_CJNE_DIR:
      begin
        branch_d = (acc_q != direct_q);  // RULE_21
        target_d = branch_d ? rel_target : next_pc;
      end
      `MBD_CLS_DJNZ_RN:
      begin
        branch_d = (reg_dec != 8'h00);  // RULE_22
        target_d = branch_d ? rel_target : next_pc;
      end
      `MBD_CLS_ACALL,
      `MBD_CLS_AJMP:
      begin
        branch_d = 1'b1;
        // page bits come from the opcode itself, so a stale third byte cannot leak in
        target_d = {next_pc[15:11], opc_hi_q, op1_q};  // RULE_24
      end
      default:
      begin
        branch_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      ready_out      <= 1'b0;
      class_out      <= `MBD_CLS_OTHER;
      bytes_out      <= 2'h0;
      cycles_out     <= 3'h0;
      done_out       <= 1'b0;
      branch_out     <= 1'b0;
      target_out     <= 16'h0000;
      bit_clear_out  <= 1'b0;
      reg_result_out <= 8'h00;
      code_addr_out  <= 16'h0000;
    end
    else
    begin
      ready_out <= !busy && !start;
      done_out  <= last;
      if (start)
      begin
        class_out  <= dec_class;
        bytes_out  <= dec_bytes;
        cycles_out <= dec_cycles;
      end
      if (last)
      begin
        branch_out    <= branch_d;
        target_out    <= target_d;
        code_addr_out <= code_addr_d;
        bit_clear_out <= (class_q == `MBD_CLS_JBC) && bit_q;  // RULE_20
        reg_result_out <= (class_q == `MBD_CLS_DJNZ_RN) ? reg_dec : acc_q;  // RULE_22
      end
      else
      begin
        branch_out    <= 1'b0;
        bit_clear_out <= 1'b0;
      end
    end
  end

endmodule

/* File: verilog/mbd_consts.vh */
`ifndef MBD_CONSTS_VH
`define MBD_CONSTS_VH

// instruction classes
`define MBD_CLS_OTHER    5'h00
`define MBD_CLS_MOV_A_RN 5'h01
`define MBD_CLS_MOV_A_DIR 5'h02
`define MBD_CLS_MOV_A_IND 5'h03
`define MBD_CLS_MOV_A_IMM 5'h04
`define MBD_CLS_MOV_RN_A 5'h05
`define MBD_CLS_MOV_RN_DIR 5'h06
`define MBD_CLS_MOV_DIR_DIR 5'h07
`define MBD_CLS_MOV_DPTR 5'h08
`define MBD_CLS_MOVC_DPTR 5'h09
`define MBD_CLS_MOVC_PC  5'h0a
`define MBD_CLS_MOVX_RD8 5'h0b
`define MBD_CLS_MOVX_WR8 5'h0c
`define MBD_CLS_MOVX_WR16 5'h0d
`define MBD_CLS_PUSH     5'h0e
`define MBD_CLS_POP      5'h0f
`define MBD_CLS_XCH_DIR  5'h10
`define MBD_CLS_XCHD     5'h11
`define MBD_CLS_JMP_IND  5'h12
`define MBD_CLS_JZ       5'h13
`define MBD_CLS_JC       5'h14
`define MBD_CLS_JBC      5'h15
`define MBD_CLS_CJNE_DIR 5'h16
`define MBD_CLS_DJNZ_RN  5'h17
`define MBD_CLS_ACALL    5'h18
`define MBD_CLS_AJMP     5'h19

// opcodes
`define MBD_OP_MOV_A_DIR   8'he5
`define MBD_OP_MOV_A_IMM   8'h74
`define MBD_OP_MOV_RN_DIR  8'ha8
`define MBD_OP_MOV_DIR_DIR 8'h85
`define MBD_OP_MOV_DPTR    8'h90
`define MBD_OP_MOVC_DPTR   8'h93
`define MBD_OP_MOVC_PC     8'h83
`define MBD_OP_MOVX_WR16   8'hf0
`define MBD_OP_PUSH        8'hc0
`define MBD_OP_POP         8'hd0
`define MBD_OP_XCH_DIR     8'hc5
`define MBD_OP_JMP_IND     8'h73
`define MBD_OP_JZ          8'h60
`define MBD_OP_JC          8'h40
`define MBD_OP_JBC         8'h10
`define MBD_OP_CJNE_DIR    8'hb5

// minimum cycle counts
`define MBD_CYC_1 3'h1
`define MBD_CYC_2 3'h2
`define MBD_CYC_3 3'h3
`define MBD_CYC_4 3'h4
`define MBD_CYC_5 3'h5

`endif

/* File: verilog/mbd_decode.v */
`include "mbd_consts.vh"

// pure combinational classifier: opcode and memory context to class, length, minimum cycles
module mbd_decode
(
  input  wire [7:0] opcode_in,
  input  wire       small_external_data_memory_in,
  input  wire       code_int_in,
  output reg  [4:0] class_out,
  output reg  [1:0] bytes_out,
  output reg  [2:0] cycles_out
);

  always @*
  begin
    class_out  = `MBD_CLS_OTHER;
    bytes_out  = 2'h1;
    cycles_out = `MBD_CYC_1;
    if (opcode_in[7:3] == 5'h1d)
    begin
      class_out = `MBD_CLS_MOV_A_RN;  // RULE_01
    end
    else if (opcode_in[7:3] == 5'h1f)
    begin
      class_out = `MBD_CLS_MOV_RN_A;  // RULE_05
    end
    else if (opcode_in[7:3] == 5'h15)
    begin
      class_out  = `MBD_CLS_MOV_RN_DIR;  // RULE_06
      bytes_out  = 2'h2;
      cycles_out = `MBD_CYC_3;
    end
    else if (opcode_in[7:3] == 5'h1b)
    begin
      class_out  = `MBD_CLS_DJNZ_RN;  // RULE_22
      bytes_out  = 2'h2;
      cycles_out = `MBD_CYC_4;
    end
    else if (opcode_in[7:1] == 7'h73)
    begin
      class_out  = `MBD_CLS_MOV_A_IND;  // RULE_03
      cycles_out = `MBD_CYC_2;
    end
    else if (opcode_in[7:1] == 7'h71)
    begin
      class_out  = `MBD_CLS_MOVX_RD8;  // RULE_11
      cycles_out = `MBD_CYC_3;
    end
    else if (opcode_in[7:1] == 7'h79)
    begin
      class_out  = `MBD_CLS_MOVX_WR8;  // RULE_12
      cycles_out = small_external_data_memory_in ? `MBD_CYC_3 : (code_int_in ? `MBD_CYC_4 : `MBD_CYC_5);
    end
    else if (opcode_in[7:1] == 7'h6b)
    begin
      class_out  = `MBD_CLS_XCHD;  // RULE_16
      cycles_out = `MBD_CYC_3;
    end
    else if (opcode_in[4:0] == 5'h11)
    begin
      class_out  = `MBD_CLS_ACALL;  // RULE_24
      bytes_out  = 2'h2;
      cycles_out = `MBD_CYC_4;
    end
    else if (opcode_in[4:0] == 5'h01)
    begin
      class_out  = `MBD_CLS_AJMP;  // RULE_24
      bytes_out  = 2'h2;
      cycles_out = `MBD_CYC_3;
    end
    else
    begin
      case (opcode_in)
        `MBD_OP_MOV_A_DIR:
        begin
          class_out = `MBD_CLS_MOV_A_DIR;  // RULE_02
          bytes_out = 2'h2;
          cycles_out = `MBD_CYC_2;
        end
        `MBD_OP_MOV_A_IMM:
        begin
          class_out = `MBD_CLS_MOV_A_IMM;  // RULE_04
          bytes_out = 2'h2;
          cycles_out = `MBD_CYC_2;
        end
        `MBD_OP_MOV_DIR_DIR:
        begin
          class_out = `MBD_CLS_MOV_DIR_DIR;  // RULE_07
          bytes_out = 2'h3;
          cycles_out = `MBD_CYC_3;
        end
        `MBD_OP_MOV_DPTR:
        begin
          class_out = `MBD_CLS_MOV_DPTR;  // RULE_08
          bytes_out = 2'h3;
          cycles_out = `MBD_CYC_3;
        end
        `MBD_OP_MOVC_DPTR:
        begin
          class_out = `MBD_CLS_MOVC_DPTR;  // RULE_09
          cycles_out = `MBD_CYC_5;
        end
        `MBD_OP_MOVC_PC:
        begin
          class_out = `MBD_CLS_MOVC_PC;  // RULE_10
          cycles_out = `MBD_CYC_4;
        end
        `MBD_OP_MOVX_WR16:
        begin
          class_out = `MBD_CLS_MOVX_WR16;  // RULE_13
          cycles_out = small_external_data_memory_in ? `MBD_CYC_2 : (code_int_in ? `MBD_CYC_3 : `MBD_CYC_4);
        end
        `MBD_OP_PUSH:
        begin
          class_out = `MBD_CLS_PUSH;  // RULE_14
          bytes_out = 2'h2;
          cycles_out = `MBD_CYC_3;
        end
        `MBD_OP_POP:
        begin
          class_out = `MBD_CLS_POP;  // RULE_14
          bytes_out = 2'h2;
          cycles_out = `MBD_CYC_2;
        end
        `MBD_OP_XCH_DIR:
        begin
          class_out = `MBD_CLS_XCH_DIR;  // RULE_15
          bytes_out = 2'h2;
          cycles_out = `MBD_CYC_3;
        end
        `MBD_OP_JMP_IND:
        begin
          class_out = `MBD_CLS_JMP_IND;  // RULE_17
          cycles_out = `MBD_CYC_5;
        end
        `MBD_OP_JZ:
        begin
          class_out = `MBD_CLS_JZ;  // RULE_18
          bytes_out = 2'h2;
          cycles_out = `MBD_CYC_4;
        end
        `MBD_OP_JC:
        begin
          class_out = `MBD_CLS_JC;  // RULE_19
          bytes_out = 2'h2;
          cycles_out = `MBD_CYC_3;
        end
        `MBD_OP_JBC:
        begin
          class_out = `MBD_CLS_JBC;  // RULE_20
          bytes_out = 2'h3;
          cycles_out = `MBD_CYC_5;
        end
        `MBD_OP_CJNE_DIR:
        begin
          class_out = `MBD_CLS_CJNE_DIR;  // RULE_21
          bytes_out = 2'h3;
          cycles_out = `MBD_CYC_5;
        end
        default:
        begin
          class_out = `MBD_CLS_OTHER;
        end
      endcase
    end
  end

endmodule

/* File: verilog/mbd_cycle_timer.v */
`include "mbd_consts.vh"

// counts execution cycles; holds the last cycle of a stretchable class while the external path waits
module mbd_cycle_timer
(
  input  wire       clk_in,
  input  wire       reset_in,
  input  wire       start_in,
  input  wire [2:0] cycles_in,
  input  wire       stretchable_in,
  input  wire       ext_wait_in,
  output wire       busy_out,
  output wire       last_out
);

  reg [2:0] remain_q;
  reg [2:0] remain_d;
  reg       stretch_q;

  assign busy_out = (remain_q != 3'h0);
  // a conditional count only ends once the external path stops waiting
  assign last_out = (remain_q == 3'h1) && !(stretch_q && ext_wait_in);  // RULE_23

  always @*
  begin
    remain_d = remain_q;
    if (start_in)
    begin
      remain_d = cycles_in;
    end
    else if (busy_out && !(remain_q == 3'h1 && stretch_q && ext_wait_in))
    begin
      remain_d = remain_q - 3'h1;
    end
  end

  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      remain_q  <= 3'h0;
      stretch_q <= 1'b0;
    end
    else
    begin
      remain_q <= remain_d;
      if (start_in)
      begin
        stretch_q <= stretchable_in;
      end
    end
  end

endmodule

/* File: verification/mbd_mem_model.sv */
// memory side: serves the direct byte and stalls the external path on request
module mbd_mem_model
(
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       take_in,
  input  wire logic [2:0] stall_len_in,
  input  wire logic [7:0] addr_in,
  output logic      [7:0] direct_data_out,
  output logic            ext_wait_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] cnt_q;

  // scrambled so a wrong address never reads back a plausible value
  assign direct_data_out = addr_in ^ 8'h5a;
  assign ext_wait_out    = (cnt_q != 3'h0);
  always @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
      cnt_q <= 3'h0;
    else if (take_in && stall_len_in != 3'h0)
      cnt_q <= stall_len_in;
    else if (cnt_q != 3'h0)
      cnt_q <= cnt_q - 3'h1;
  end
endmodule

/* File: verification/mbd_core_assertions.sv */
module mbd_core_checker
(
  input wire       clk_in,
  input wire       reset_in,
  input wire       issue_in,
  input wire [7:0] opcode_in,
  input wire [7:0] acc_in,
  input wire       carry_in,
  input wire       small_external_data_memory_in,
  input wire       ext_wait_in,
  input wire       ready_out,
  input wire [4:0] class_out,
  input wire [1:0] bytes_out,
  input wire [2:0] cycles_out,
  input wire       done_out,
  input wire       branch_out,
  input wire       bit_clear_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  wire take = ready_out && issue_in;

  rn_to_acc_a : assert property (take && opcode_in[7:3] == 5'h1d |-> ##2 done_out && cycles_out == 3'h1)
    else $error("register to acc timing wrong");
  dir_to_acc_a : assert property (take && opcode_in == 8'he5 |-> ##3 done_out && bytes_out == 2'h2)
    else $error("direct to acc timing wrong");
  imm_to_acc_a : assert property (take && opcode_in == 8'h74 |-> ##1 bytes_out == 2'h2 && cycles_out == 3'h2 ##2 done_out)
    else $error("immediate to acc wrong");
  code_dptr_a : assert property (take && opcode_in == 8'h93 |-> ##2 (!done_out)[*4] ##1 done_out)
    else $error("code fetch via pointer timing wrong");
  push_time_a : assert property (take && opcode_in == 8'hc0 |-> ##4 done_out && bytes_out == 2'h2)
    else $error("push timing wrong");
  jz_zero_a : assert property (take && opcode_in == 8'h60 && acc_in == 8'h00 |-> ##5 done_out && branch_out)
    else $error("branch on zero not taken");
  jc_clear_a : assert property (take && opcode_in == 8'h40 && !carry_in |-> ##4 done_out && !branch_out)
    else $error("branch on carry wrong");
  bit_clear_a : assert property (bit_clear_out |-> done_out && class_out == 5'h15)
    else $error("bit clear outside its branch");
  small_wr_a : assert property ((take && opcode_in == 8'hf0 && small_external_data_memory_in) ##1 (!ext_wait_in)[*2] |-> ##1 done_out)
    else $error("small external write timing wrong");
  stall_hold_a : assert property ((take && opcode_in == 8'hf0 && small_external_data_memory_in) ##1 ext_wait_in[*2] |-> ##1 !done_out)
    else $error("external wait ignored");
endmodule

bind mbd_core mbd_core_checker chk_i (.*);

/* File: verification/mbd_core_tb_top.sv */
module mbd_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_in, reset_in, issue_in, carry_in, bit_in, small_external_data_memory_in, code_int_in, br, bc;
  logic [7:0]  opcode_in, operand1_in, operand2_in, acc_in, reg_data_in;
  logic [15:0] pc_in, dptr_in, w;
  logic [2:0]  stall_len;
  wire         ext_wait_in, ready_out, done_out, branch_out, bit_clear_out;
  wire [7:0]   direct_data_in, reg_result_out;
  wire [4:0]   class_out;
  wire [1:0]   bytes_out;
  wire [2:0]   cycles_out;
  wire [15:0]  target_out, code_addr_out;
  integer      err_total = 0, n_checks = 0, cyc = 0, n, i;
  logic [15:0] tbl [0:19] = '{16'he811, 16'he522, 16'he612, 16'h7422,
                              16'hff11, 16'haf23, 16'h8533, 16'h9033,
                              16'h9315, 16'h8314, 16'hc023, 16'hd022,
                              16'hc523, 16'hd713, 16'h7315, 16'h6024,
                              16'h4023, 16'h1035, 16'hb535, 16'hd824};
  logic [15:0] xt [0:7] = '{16'hf214, 16'hf205, 16'hf223, 16'he203,
                            16'he333, 16'hf013, 16'hf004, 16'hf032};

  mbd_core dut (.clk_in(clk_in), .reset_in(reset_in), .issue_in(issue_in), .opcode_in(opcode_in),
    .operand1_in(operand1_in), .operand2_in(operand2_in), .pc_in(pc_in), .acc_in(acc_in), .dptr_in(dptr_in),
    .carry_in(carry_in), .bit_in(bit_in), .direct_data_in(direct_data_in), .reg_data_in(reg_data_in),
    .small_external_data_memory_in(small_external_data_memory_in), .code_int_in(code_int_in), .ext_wait_in(ext_wait_in), .ready_out(ready_out),
    .class_out(class_out), .bytes_out(bytes_out), .cycles_out(cycles_out), .done_out(done_out),
    .branch_out(branch_out), .target_out(target_out), .bit_clear_out(bit_clear_out),
    .reg_result_out(reg_result_out), .code_addr_out(code_addr_out));
  mbd_mem_model mem (.clk_in(clk_in), .reset_in(reset_in), .take_in(issue_in && ready_out),
    .stall_len_in(stall_len), .addr_in(operand1_in), .direct_data_out(direct_data_in), .ext_wait_out(ext_wait_in));

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  task end_of_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_in)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      err_total = err_total + 1;
      end_of_test();
    end
  end

  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  // issue once idle, then count edges until the completion pulse
  task run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
    while (ready_out !== 1'b1)
    begin
      @(posedge clk_in);
      #1;
    end
    opcode_in = op;
    operand1_in = a;
    operand2_in = b;
    issue_in = 1'b1;
    @(posedge clk_in);
    #1 issue_in = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 20)
    begin
      @(posedge clk_in);
      #1 n = n + 1;
    end
    br = branch_out;
    bc = bit_clear_out;
  endtask

  task t_table;
    for (i = 0; i < 20; i++)
    begin
      w = tbl[i];
      run(w[15:8], 8'h10, 8'h20);
      chk("cycles", {12'h000, w[3:0]}, n[15:0]);
      chk("cycles_out", {12'h000, w[3:0]}, {13'h0000, cycles_out});
      chk("bytes_out", {12'h000, w[7:4]}, {14'h0000, bytes_out});
    end
  endtask

  task t_external;
    for (i = 0; i < 8; i++)
    begin
      w = xt[i];
      small_external_data_memory_in = w[5];
      code_int_in = w[4];
      run(w[15:8], 8'h00, 8'h00);
      chk("ext cycles", {12'h000, w[3:0]}, n[15:0]);
    end
    stall_len = 3'h3;
    run(8'hf0, 8'h00, 8'h00);
    stall_len = 3'h0;
    chk("stretched", 16'h0004, n[15:0]);
    small_external_data_memory_in = 1'b0;
  endtask

  task t_branch;
    pc_in = 16'h1230;
    run(8'h60, 8'hfe, 8'h00);
    chk("jz target", 16'h1230, target_out);
    acc_in = 8'h01;
    run(8'h60, 8'hfe, 8'h00);
    chk("jz skip", 16'h1232, {target_out[15:1], br});
    carry_in = 1'b1;
    run(8'h40, 8'h05, 8'h00);
    chk("jc", 16'h1237, {target_out[15:1], br});
    bit_in = 1'b1;
    run(8'h10, 8'h00, 8'h10);
    chk("jbc", 16'h1243, target_out);
    chk("jbc clear", 16'h0003, {14'h0000, bc, br});
    chk("jbc class", 16'h0015, {11'h000, class_out});
    run(8'hb5, 8'h33, 8'h04);
    chk("cjne", 16'h1237, {target_out[15:1], br});
    reg_data_in = 8'h01;
    run(8'hd9, 8'h02, 8'h00);
    chk("djnz last", 16'h0000, {7'h00, reg_result_out, br});
    reg_data_in = 8'h03;
    run(8'hd9, 8'h02, 8'h00);
    chk("djnz loop", 16'h1235, {target_out[15:1], br});
    chk("djnz value", 16'h0002, {8'h00, reg_result_out});
    dptr_in = 16'h4000;
    run(8'h73, 8'h00, 8'h00);
    chk("jmp ind", 16'h4001, target_out);
    run(8'h93, 8'h00, 8'h00);
    chk("code dptr", 16'h4001, code_addr_out);
    run(8'h83, 8'h00, 8'h00);
    chk("code pc", 16'h1232, code_addr_out);
    run(8'ha1, 8'h55, 8'h00);
    chk("abs jump", 16'h1555, target_out);
    run(8'h71, 8'haa, 8'h00);
    chk("abs call", 16'h13aa, target_out);
    chk("abs call cycles", 16'h0004, n[15:0]);
  endtask

  initial
  begin
    {issue_in, carry_in, bit_in, small_external_data_memory_in, code_int_in} = 5'h00;
    {opcode_in, operand1_in, operand2_in, acc_in, reg_data_in} = 40'h0;
    {pc_in, dptr_in} = 32'h0;
    stall_len = 3'h0;
    reset_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1 reset_in = 1'b0;
    @(posedge clk_in);
    #1;
    t_table();
    t_external();
    t_branch();
    end_of_test();
  end
endmodule
